// [shared/evr_pkg.sv]
// Constants and types shared by the peripheral event router.
// Assumes a single peripheral clock and generators sampled synchronously.
//
// How it works
// - Six channels route events in parallel.
// - One generator per channel, many users listen.
// - Generator select picks each channel's source.
// - Channels disconnected from generators after reset.
// - Each channel has async and sync subchannel.
// - Sync subchannel lags two to three cycles.
// - Each user selects its channel independently.
// - Routing continues in active, idle, standby.
// - Async subchannel is registered, one clock edge behind.
// - Software may inject events onto channels.
// - One event output pin per I/O port.
// - Sync edge users need clock-sourced events.
package evr_pkg;
  localparam int unsigned EVR_NUM_CH = 6;
  localparam int unsigned EVR_NUM_GEN = 16;
  localparam int unsigned EVR_NUM_USER = 8;
  localparam int unsigned EVR_NUM_PORT = 4;
  localparam int unsigned EVR_SYNC_STAGES = 2;
  localparam int unsigned EVR_GSEL_W = 8;
  localparam int unsigned EVR_USEL_W = 8;
  // Generator select 0 means no generator; 1..EVR_NUM_GEN pick gen_evt[n-1].
  localparam logic [7:0] EVR_GSEL_OFF = 8'h00;
  // User select 0 means off; 1..EVR_NUM_CH pick channel n-1.
  localparam logic [7:0] EVR_USEL_OFF = 8'h00;
  localparam logic [7:0] EVR_SEL_BASE = 8'h01;
  // Index of the sync character generator among the generator inputs.
  localparam int unsigned EVR_GEN_SYNC_CHAR = 0;
endpackage

// [src/evr_sync.sv]
// Two-stage synchronizer for one event bit onto the peripheral clock.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/10ps
module evr_sync
  import evr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;

  // The first stage feeds only the second one.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else if (clk_en)
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // evr_sync

// [src/evr_router.sv]
// Peripheral event router: generator muxes, subchannels, user muxes and
// port event outputs.
// Assumes generator inputs and select values are sampled on clock.
`timescale 1ns/10ps
module evr_router
  import evr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [EVR_NUM_GEN-1:0] gen_evt,
  input wire logic [EVR_NUM_CH*EVR_GSEL_W-1:0] channel_generator_select,
  input wire logic [EVR_NUM_USER*EVR_USEL_W-1:0] user_channel_select,
  input wire logic [EVR_NUM_PORT*EVR_USEL_W-1:0] port_channel_select,
  input wire logic [EVR_NUM_CH-1:0] sw_inject,
  output logic [EVR_NUM_CH-1:0] ch_async_q,
  output logic [EVR_NUM_CH-1:0] ch_sync_q,
  output logic [EVR_NUM_USER-1:0] user_sync_evt_q,
  output logic [EVR_NUM_USER-1:0] user_async_evt_q,
  output logic [EVR_NUM_PORT-1:0] port_event_output_q
);
  // ****************************************************************
  // Channel generator multiplexers and subchannels
  // ****************************************************************
  logic [EVR_NUM_CH-1:0] ch_raw;
  logic [EVR_NUM_CH-1:0] ch_synced;
  logic [EVR_NUM_CH-1:0] inj_prev_q;
  logic [EVR_NUM_CH-1:0] inj_pulse;

  // An injection held high for many cycles still makes a single pulse.
  assign inj_pulse = sw_inject & ~inj_prev_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      inj_prev_q <= '0;
    else if (clk_en)
      inj_prev_q <= sw_inject;
  end

  for (genvar c = 0; c < EVR_NUM_CH; c++)
  begin : g_ch
    logic [EVR_GSEL_W-1:0] gsel;
    assign gsel = channel_generator_select[c*EVR_GSEL_W +: EVR_GSEL_W];

    // Select 0 (the reset default upstream) connects nothing.
    always_comb
    begin
      ch_raw[c] = 1'b0;
      for (int g = 0; g < EVR_NUM_GEN; g++)
      begin
        if (gsel == EVR_SEL_BASE + EVR_GSEL_W'(g))
          ch_raw[c] = gen_evt[g];
      end
    end

    evr_sync u_sync (
      .clock(clock),
      .resetn(resetn),
      .clk_en(clk_en),
      .async_in(ch_raw[c]),
      .sync_out(ch_synced[c])
    );
  end

  // The asynchronous path is a single register so that every output is
  // driven from a flip-flop; a truly clockless path would bypass it.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ch_async_q <= '0;
      ch_sync_q <= '0;
    end
    else if (clk_en)
    begin
      ch_async_q <= ch_raw | inj_pulse;
      ch_sync_q <= ch_synced | inj_pulse;
    end
  end

  // ****************************************************************
  // User and port multiplexers
  // ****************************************************************
  logic [EVR_NUM_USER-1:0] user_sync_d;
  logic [EVR_NUM_USER-1:0] user_async_d;
  logic [EVR_NUM_PORT-1:0] port_d;

  for (genvar u = 0; u < EVR_NUM_USER; u++)
  begin : g_user
    logic [EVR_USEL_W-1:0] usel;
    assign usel = user_channel_select[u*EVR_USEL_W +: EVR_USEL_W];
    always_comb
    begin
      user_sync_d[u] = 1'b0;
      user_async_d[u] = 1'b0;
      for (int c = 0; c < EVR_NUM_CH; c++)
      begin
        if (usel == EVR_SEL_BASE + EVR_USEL_W'(c))
        begin
          user_sync_d[u] = ch_sync_q[c];
          user_async_d[u] = ch_async_q[c];
        end
      end
    end
  end

  for (genvar p = 0; p < EVR_NUM_PORT; p++)
  begin : g_port
    logic [EVR_USEL_W-1:0] psel;
    assign psel = port_channel_select[p*EVR_USEL_W +: EVR_USEL_W];
    always_comb
    begin
      port_d[p] = 1'b0;
      for (int c = 0; c < EVR_NUM_CH; c++)
      begin
        if (psel == EVR_SEL_BASE + EVR_USEL_W'(c))
          port_d[p] = ch_async_q[c];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      user_sync_evt_q <= '0;
      user_async_evt_q <= '0;
      port_event_output_q <= '0;
    end
    else if (clk_en)
    begin
      user_sync_evt_q <= user_sync_d;
      user_async_evt_q <= user_async_d;
      port_event_output_q <= port_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  for (genvar c = 0; c < EVR_NUM_CH; c++)
  begin : g_chk
    AST_SYNC_LAG: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && $past(clk_en) && $past(clk_en, EVR_SYNC_STAGES)
        && ch_raw[c] && $past(ch_raw[c], EVR_SYNC_STAGES))
      |=> ch_sync_q[c])
      else $error("sync subchannel missed a steady event");
    AST_OFF_QUIET: assert property (
      @(posedge clock) disable iff (!resetn)
      (channel_generator_select[c*EVR_GSEL_W +: EVR_GSEL_W] == EVR_GSEL_OFF
        && !inj_pulse[c] && clk_en) |=> !ch_async_q[c])
      else $error("disconnected channel carried an event");
    AST_ASYNC_FOLLOW: assert property (
      @(posedge clock) disable iff (!resetn)
      clk_en |=> ch_async_q[c] == ($past(ch_raw[c]) | $past(inj_pulse[c])))
      else $error("async subchannel does not follow generator");
    AST_INJ_PULSE: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && inj_pulse[c]) |=> ch_sync_q[c] && ch_async_q[c])
      else $error("injection did not reach both subchannels");
    AST_INJ_ONCE: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && inj_pulse[c]) ##1 clk_en |-> !inj_pulse[c])
      else $error("held injection produced a second pulse");
    // Select values past the last generator decode as off.
    AST_GSEL_RANGE: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && !inj_pulse[c]
        && channel_generator_select[c*EVR_GSEL_W +: EVR_GSEL_W]
        > EVR_GSEL_W'(EVR_NUM_GEN)) |=> !ch_async_q[c])
      else $error("out of range select carried an event");
    AST_SYNC_CHAR: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && !inj_pulse[c]
        && channel_generator_select[c*EVR_GSEL_W +: EVR_GSEL_W]
        == EVR_SEL_BASE + EVR_GSEL_W'(EVR_GEN_SYNC_CHAR))
      |=> ch_async_q[c] == $past(gen_evt[EVR_GEN_SYNC_CHAR]))
      else $error("sync character event not carried as a level");
  end

  for (genvar u = 0; u < EVR_NUM_USER; u++)
  begin : g_uchk
    AST_USER_OFF: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && user_channel_select[u*EVR_USEL_W +: EVR_USEL_W]
        == EVR_USEL_OFF) |=> !user_sync_evt_q[u] && !user_async_evt_q[u])
      else $error("unselected user received an event");
    AST_USER_CH0: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && user_channel_select[u*EVR_USEL_W +: EVR_USEL_W]
        == EVR_SEL_BASE) |=> user_sync_evt_q[u] == $past(ch_sync_q[0]))
      else $error("user on channel 0 does not mirror it");
    AST_USER_ASYNC: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && user_channel_select[u*EVR_USEL_W +: EVR_USEL_W]
        == EVR_SEL_BASE) |=> user_async_evt_q[u] == $past(ch_async_q[0]))
      else $error("async user on channel 0 does not mirror it");
  end

  for (genvar p = 0; p < EVR_NUM_PORT; p++)
  begin : g_pchk
    AST_PORT_CH0: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && port_channel_select[p*EVR_USEL_W +: EVR_USEL_W]
        == EVR_SEL_BASE) |=> port_event_output_q[p] == $past(ch_async_q[0]))
      else $error("port output does not mirror channel 0");
    AST_PORT_OFF: assert property (
      @(posedge clock) disable iff (!resetn)
      (clk_en && port_channel_select[p*EVR_USEL_W +: EVR_USEL_W]
        == EVR_USEL_OFF) |=> !port_event_output_q[p])
      else $error("unselected port pin carried an event");
  end

  // ****************************************************************
  // Clock enable check
  // ****************************************************************
  // A low enable must hold every output, so a gated clock loses no
  // routed state; events arriving meanwhile are not buffered.
  AST_FREEZE: assert property (
    @(posedge clock) disable iff (!resetn)
    !clk_en |=> $stable(ch_async_q) && $stable(ch_sync_q)
      && $stable(user_sync_evt_q) && $stable(user_async_evt_q)
      && $stable(port_event_output_q))
    else $error("outputs moved while the clock enable was low");
endmodule // evr_router

// [verif/evr_gen_model.sv]
// Model of the event generators that feed the router.
// Assumes its tasks are called from the bench just after a falling edge.
`timescale 1ns/10ps
module evr_gen_model
  import evr_pkg::*;
(
  input wire logic clock,
  output logic [EVR_NUM_GEN-1:0] gen_evt
);
  initial gen_evt = '0;
  // A pulse generator asserts for exactly one clock cycle.
  task automatic pulse(input int g);
    gen_evt[g] = 1'b1;
    @(negedge clock);
    gen_evt[g] = 1'b0;
  endtask
  // Levels hold for many cycles, long enough to cross the synchronizer.
  task automatic level(input int g, input logic v);
    gen_evt[g] = v;
  endtask
endmodule // evr_gen_model

// [verif/tb_evr_router.sv]
// Self-checking bench for the event router.
// Assumes the generator model drives gen_evt after falling edges.
`timescale 1ns/10ps
module tb_evr_router;
  import evr_pkg::*;
  logic clock = 0, resetn = 0;
  logic [47:0] cgs = '0;
  logic [63:0] ucs = '0;
  logic [31:0] pcs = '0;
  logic [5:0] inj = '0;
  logic ce = 1'b1;
  logic [15:0] gen;
  logic [5:0] ca, cs;
  logic [7:0] us, ua;
  logic [3:0] po;
  int n_fail = 0, tests_run = 0;
  evr_gen_model i_evr_gen_model (.clock(clock), .gen_evt(gen));
  evr_router i_evr_router (.clock(clock), .resetn(resetn),
    .clk_en(ce), .gen_evt(gen), .channel_generator_select(cgs),
    .user_channel_select(ucs), .port_channel_select(pcs),
    .sw_inject(inj), .ch_async_q(ca), .ch_sync_q(cs),
    .user_sync_evt_q(us), .user_async_evt_q(ua),
    .port_event_output_q(po));
  initial forever #20 clock = ~clock;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("run=%0d fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Unselected channels ignore every generator after reset.
  task automatic t_reset();
    for (int g = 0; g < 16; g++) i_evr_gen_model.level(g, 1'b1);
    cyc(5);
    chk({2'h0, ca}, 8'h00);
    chk({2'h0, cs}, 8'h00);
    for (int g = 0; g < 16; g++) i_evr_gen_model.level(g, 1'b0);
    cyc(5);
    $display("reset test done");
  endtask
  task automatic t_route();
    cgs[7:0] = 8'h01;
    cyc(1);
    ucs[7:0] = 8'h01;
    pcs[7:0] = 8'h01;
    cyc(1);
    i_evr_gen_model.level(0, 1'b1);
    cyc(1);
    chk({2'h0, ca}, 8'h01);
    chk({2'h0, cs}, 8'h00);
    cyc(1);
    chk(ua, 8'h01);
    chk({4'h0, po}, 8'h01);
    chk(us, 8'h00);
    cyc(1);
    chk({2'h0, cs}, 8'h01);
    cyc(1);
    chk(us, 8'h01);
    i_evr_gen_model.level(0, 1'b0);
    cyc(1);
    chk({2'h0, ca}, 8'h00);
    cgs[7:0] = 8'h00;
    cyc(4);
    $display("route test done");
  endtask
  // Channel c takes generator c+2; channel 5 has an out-of-range select.
  task automatic t_parallel();
    for (int c = 0; c < 5; c++) cgs[8*c +: 8] = 8'(c + 3);
    cgs[47:40] = 8'h11;
    for (int g = 2; g < 8; g += 2) i_evr_gen_model.level(g, 1'b1);
    cyc(1);
    chk({2'h0, ca}, 8'h15);
    cyc(2);
    chk({2'h0, cs}, 8'h15);
    i_evr_gen_model.level(15, 1'b1);
    i_evr_gen_model.level(0, 1'b1);
    i_evr_gen_model.pulse(3);
    chk({2'h0, ca}, 8'h17);
    cyc(1);
    chk({2'h0, ca}, 8'h15);
    for (int g = 0; g < 16; g++) i_evr_gen_model.level(g, 1'b0);
    cgs = '0;
    cyc(5);
    $display("parallel test done");
  endtask
  task automatic t_inject();
    inj[5] = 1'b1;
    cyc(1);
    chk({2'h0, ca}, 8'h20);
    chk({2'h0, cs}, 8'h20);
    cyc(1);
    chk({2'h0, ca | cs}, 8'h00);
    inj = '0;
    cyc(2);
    $display("inject test done");
  endtask
  // A low clock enable holds the routed state until it rises again.
  task automatic t_freeze();
    cgs[7:0] = 8'h01;
    ce = 1'b0;
    i_evr_gen_model.level(0, 1'b1);
    cyc(3);
    chk({2'h0, ca | cs}, 8'h00);
    chk(ua | us, 8'h00);
    ce = 1'b1;
    cyc(1);
    chk({2'h0, ca}, 8'h01);
    i_evr_gen_model.level(0, 1'b0);
    cgs = '0;
    cyc(4);
    $display("freeze test done");
  endtask
  initial
  begin
    cyc(10);
    resetn = 1'b1;
    cyc(2);
    t_reset();
    t_route();
    t_parallel();
    t_inject();
    t_freeze();
    summarize();
  end
  initial
  begin
    #(40 * 400);
    n_fail++;
    summarize();
  end
endmodule // tb_evr_router
